// ===== hw/pus_sequencer.sv
// power-up reset sequencer: reset release, clock defaults, pins, regulator mode
// Functional notes
// - the chip is held in reset until both io supply and core supply report stable.
// - after power-up the lowest performance level is selected and the regulator targets it.
// - after release the chip runs from the startup oscillator, enabled and set to 4MHz.
// - generator 0 takes the startup oscillator and drives the main system clock.
// - only a default subset of system clocks runs from generator 0, others stay off until software.
// - all io pins are tri-stated after power-up except the debug clock pin, an input with pull-up.
// - the regulator defaults to linear mode while running.
// - software can switch the regulator to switching mode on the fly while active.
// - standby sleep puts the regulator in low-power mode once the chip is out of reset; while held in reset it stays linear.
// - backup sleep shuts the regulator down.
// - the regulator mode is chosen by the power manager sleep state together with the software switching request.
// - on release the cpu fetches its start vectors from address zero.
`timescale 1ns/1ns
module pus_sequencer #(
	parameter int STABLE_CYCLES = pus_pkg::PUS_STABLE_CYCLES,
	parameter int NUM_GCLK = pus_pkg::PUS_NUM_GCLK,
	parameter int NUM_PINS = pus_pkg::PUS_PIN_GROUP
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic io_supply_ok,
	input wire logic core_supply_ok,
	input wire pus_pkg::pus_sleep_t pm_sleep_state,
	input wire logic sw_switching_req,
	input wire logic [NUM_GCLK-1:0] sw_gclk_enable,
	input wire logic sw_gclk_write,
	output logic chip_reset_n,
	output logic perf_level,
	output pus_pkg::pus_reg_mode_t reg_mode,
	output pus_pkg::pus_clk_cfg_t clk_cfg,
	output logic [NUM_PINS-1:0] pin_oe_n,
	output logic [NUM_PINS-1:0] pin_pull_up,
	output logic [NUM_PINS-1:0] pin_input_en,
	output logic [31:0] cpu_boot_addr,
	output logic cpu_fetch_start
);

	// ==========================================
	// elaboration checks
	// refused at elaboration, so a bad build never reaches a clock edge
	// the counter is eight bits and the default clock mask is eight clocks wide
	if (STABLE_CYCLES < 1 || STABLE_CYCLES > 255) begin : g_bad_stable
		$error("stable cycle count out of range");
	end
	if (NUM_GCLK != 8) begin : g_bad_gclk
		$error("clock mask width must be eight");
	end
	if (NUM_PINS < 31) begin : g_bad_pins
		$error("pin group must hold the debug clock pin");
	end

	localparam int DBG_PIN = 30;

	// ==========================================
	// supply stability synchronisers
	logic io_meta;
	logic io_sync;
	logic core_meta;
	logic core_sync;
	logic [7:0] stable_cnt;
	logic [7:0] next_stable_cnt;
	pus_pkg::pus_state_t state;
	pus_pkg::pus_state_t next_state;

	// two stages per supply indication; only the second is ever looked at
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			io_meta <= 1'b0;
			io_sync <= 1'b0;
			core_meta <= 1'b0;
			core_sync <= 1'b0;
		end else begin
			io_meta <= io_supply_ok;
			io_sync <= io_meta;
			core_meta <= core_supply_ok;
			core_sync <= core_meta;
		end
	end

	// ==========================================
	// sequencer state machine
	// a glitch on either supply restarts the count, so short dips never release
	always_comb begin
		next_state = state;
		next_stable_cnt = stable_cnt;
		case (state)
			pus_pkg::PUS_ST_HOLD: begin
				if (io_sync && core_sync) begin
					next_stable_cnt = stable_cnt + 8'h01;
					if (stable_cnt == 8'(STABLE_CYCLES - 1)) begin
						next_state = pus_pkg::PUS_ST_SYNC;
					end
				end else begin
					next_stable_cnt = 8'h00;
				end
			end
			pus_pkg::PUS_ST_SYNC: begin
				if (io_sync && core_sync) begin
					next_state = pus_pkg::PUS_ST_RUN;
				end else begin
					next_state = pus_pkg::PUS_ST_HOLD;
					next_stable_cnt = 8'h00;
				end
			end
			pus_pkg::PUS_ST_RUN: begin
				if (!(io_sync && core_sync)) begin
					next_state = pus_pkg::PUS_ST_HOLD;
					next_stable_cnt = 8'h00;
				end
			end
			default: begin
				next_state = pus_pkg::PUS_ST_HOLD;
				next_stable_cnt = 8'h00;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= pus_pkg::PUS_ST_HOLD;
			stable_cnt <= 8'h00;
		end else begin
			state <= next_state;
			stable_cnt <= next_stable_cnt;
		end
	end

	// ==========================================
	// reset, boot vector and performance level outputs
	logic next_chip_reset_n;
	logic next_fetch;
	logic next_perf_level;

	always_comb begin
		next_chip_reset_n = (next_state == pus_pkg::PUS_ST_RUN);
		next_fetch = (next_state == pus_pkg::PUS_ST_RUN) && (state != pus_pkg::PUS_ST_RUN);
		next_perf_level = pus_pkg::PUS_LOWEST_PERF_LEVEL;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			chip_reset_n <= 1'b0;
			cpu_fetch_start <= 1'b0;
			perf_level <= pus_pkg::PUS_LOWEST_PERF_LEVEL;
			cpu_boot_addr <= pus_pkg::PUS_RESET_ADDRESS;
		end else begin
			chip_reset_n <= next_chip_reset_n;
			cpu_fetch_start <= next_fetch;
			perf_level <= next_perf_level;
			cpu_boot_addr <= pus_pkg::PUS_RESET_ADDRESS;
		end
	end

	// ==========================================
	// clock configuration
	pus_pkg::pus_clk_cfg_t next_clk_cfg;

	always_comb begin
		next_clk_cfg = clk_cfg;
		if (!next_chip_reset_n) begin
			next_clk_cfg.osc_enable = 1'b1;
			next_clk_cfg.osc_freq_sel = pus_pkg::PUS_OSC_FREQ_SEL_4MHZ;
			next_clk_cfg.main_gen = pus_pkg::PUS_MAIN_GEN_INDEX;
			next_clk_cfg.gclk_enable = pus_pkg::PUS_DEFAULT_CLK_MASK;
		end else if (sw_gclk_write) begin
			next_clk_cfg.gclk_enable = sw_gclk_enable;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_cfg <= '{osc_enable: 1'b1, osc_freq_sel: pus_pkg::PUS_OSC_FREQ_SEL_4MHZ,
				main_gen: pus_pkg::PUS_MAIN_GEN_INDEX, gclk_enable: pus_pkg::PUS_DEFAULT_CLK_MASK};
		end else begin
			clk_cfg <= next_clk_cfg;
		end
	end

	// ==========================================
	// io pin defaults
	// pins keep reset defaults; they hold the same values once the chip runs
	generate
		for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					pin_oe_n[i] <= 1'b1;
					pin_pull_up[i] <= (i == DBG_PIN) ? 1'b1 : 1'b0;
					pin_input_en[i] <= (i == DBG_PIN) ? 1'b1 : 1'b0;
				end else begin
					pin_oe_n[i] <= 1'b1;
					pin_pull_up[i] <= (i == DBG_PIN) ? 1'b1 : 1'b0;
					pin_input_en[i] <= (i == DBG_PIN) ? 1'b1 : 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================
	// regulator mode selection
	logic sw_switching;
	logic next_sw_switching;
	pus_pkg::pus_reg_mode_t next_reg_mode;

	always_comb begin
		next_sw_switching = sw_switching;
		if (!next_chip_reset_n) begin
			next_sw_switching = 1'b0;
		end else if (pm_sleep_state == pus_pkg::PUS_SLEEP_ACTIVE) begin
			next_sw_switching = sw_switching_req;
		end
		case (pm_sleep_state)
			pus_pkg::PUS_SLEEP_STANDBY: begin
				next_reg_mode = pus_pkg::PUS_REG_LOW_POWER;
			end
			pus_pkg::PUS_SLEEP_BACKUP: begin
				next_reg_mode = pus_pkg::PUS_REG_SHUTDOWN;
			end
			default: begin
				next_reg_mode = next_sw_switching ? pus_pkg::PUS_REG_SWITCHING : pus_pkg::PUS_REG_LINEAR;
			end
		endcase
		if (!next_chip_reset_n && pm_sleep_state != pus_pkg::PUS_SLEEP_BACKUP) begin
			next_reg_mode = pus_pkg::PUS_REG_LINEAR;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sw_switching <= 1'b0;
			reg_mode <= pus_pkg::PUS_REG_LINEAR;
		end else begin
			sw_switching <= next_sw_switching;
			reg_mode <= next_reg_mode;
		end
	end

	// ==========================================
	// assertions
	// release needs supplies
	a_release_needs_supply: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(chip_reset_n) |-> $past(io_sync) && $past(core_sync) && $past(io_sync, 2))
		else $error("reset released without stable supplies");
	a_supply_drop_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(chip_reset_n && !(io_sync && core_sync)) |=> !chip_reset_n)
		else $error("reset not reasserted on supply loss");
	a_perf_level_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(chip_reset_n) |-> perf_level == pus_pkg::PUS_LOWEST_PERF_LEVEL)
		else $error("wrong performance level at release");
	a_osc_default: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(chip_reset_n) |-> clk_cfg.osc_enable && clk_cfg.osc_freq_sel == pus_pkg::PUS_OSC_FREQ_SEL_4MHZ)
		else $error("startup oscillator not at default");
	a_clk_mask_default: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(chip_reset_n) |-> clk_cfg.gclk_enable == pus_pkg::PUS_DEFAULT_CLK_MASK
			&& clk_cfg.main_gen == pus_pkg::PUS_MAIN_GEN_INDEX)
		else $error("clock defaults wrong at release");
	a_debug_pin_cfg: assert property (@(posedge sys_clk) disable iff (!reset_n)
		pin_oe_n[DBG_PIN] && pin_pull_up[DBG_PIN] && pin_input_en[DBG_PIN] && pin_oe_n[0] && !pin_pull_up[0])
		else $error("pin defaults wrong");
	a_active_linear: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(pm_sleep_state == pus_pkg::PUS_SLEEP_ACTIVE && !sw_switching_req) |=> reg_mode == pus_pkg::PUS_REG_LINEAR)
		else $error("regulator not linear while active");
	// standby low power, only once the chip is out of reset
	a_standby_lp: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(next_chip_reset_n && pm_sleep_state == pus_pkg::PUS_SLEEP_STANDBY)
		|=> reg_mode == pus_pkg::PUS_REG_LOW_POWER)
		else $error("standby regulator mode wrong");
	a_backup_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		pm_sleep_state == pus_pkg::PUS_SLEEP_BACKUP |=> reg_mode == pus_pkg::PUS_REG_SHUTDOWN)
		else $error("backup regulator not shut down");
	a_switch_on_fly: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(chip_reset_n && sw_switching_req && pm_sleep_state == pus_pkg::PUS_SLEEP_ACTIVE && io_sync && core_sync)
		|=> reg_mode == pus_pkg::PUS_REG_SWITCHING)
		else $error("switching mode not taken");
	a_fetch_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
		cpu_fetch_start |-> $rose(chip_reset_n) && cpu_boot_addr == pus_pkg::PUS_RESET_ADDRESS ##1 !cpu_fetch_start)
		else $error("fetch start pulse wrong");
endmodule

// ===== hw/pus_pkg.sv
// package of constants and carrier types for the power-up reset sequencer
package pus_pkg;

	// ==========================================
	// performance levels and clocks
	localparam logic [0:0] PUS_LOWEST_PERF_LEVEL = 1'h0;
	localparam int PUS_STARTUP_FREQ_MHZ = 4;
	localparam logic [1:0] PUS_OSC_FREQ_SEL_4MHZ = 2'h0;
	localparam logic [3:0] PUS_MAIN_GEN_INDEX = 4'h0;
	localparam int PUS_NUM_GCLK = 8;
	localparam logic [7:0] PUS_DEFAULT_CLK_MASK = 8'h0F;
	localparam logic [31:0] PUS_RESET_ADDRESS = 32'h00000000;

	// ==========================================
	// supply stability filtering
	localparam int PUS_STABLE_CYCLES = 4;
	localparam int PUS_SYNC_STAGES = 2;

	// ==========================================
	// regulator modes
	typedef enum logic [3:0] {
		PUS_REG_LINEAR = 4'h1,
		PUS_REG_SWITCHING = 4'h2,
		PUS_REG_LOW_POWER = 4'h4,
		PUS_REG_SHUTDOWN = 4'h8
	} pus_reg_mode_t;

	// power manager sleep states
	typedef enum logic [1:0] {
		PUS_SLEEP_ACTIVE = 2'h0,
		PUS_SLEEP_IDLE = 2'h1,
		PUS_SLEEP_STANDBY = 2'h2,
		PUS_SLEEP_BACKUP = 2'h3
	} pus_sleep_t;

	// sequencer states
	typedef enum logic [2:0] {
		PUS_ST_HOLD = 3'h1,
		PUS_ST_SYNC = 3'h2,
		PUS_ST_RUN = 3'h4
	} pus_state_t;

	// clock configuration bundle
	typedef struct packed {
		logic osc_enable;
		logic [1:0] osc_freq_sel;
		logic [3:0] main_gen;
		logic [7:0] gclk_enable;
	} pus_clk_cfg_t;

	// pin configuration bundle for the debug clock pin
	typedef struct packed {
		logic input_enable;
		logic pull_up;
		logic drive_n;
	} pus_pin_cfg_t;

	localparam int PUS_PIN_GROUP = 32;
endpackage

// ===== dv/pus_supply_model.sv
// partner model of the supply monitors and the sleep controller
`timescale 1ns/1ns
module pus_supply_model (
	input wire logic sys_clk,
	input wire logic io_on,
	input wire logic core_on,
	input wire logic [3:0] lag,
	input wire pus_pkg::pus_sleep_t sleep_req,
	output logic io_supply_ok,
	output logic core_supply_ok,
	output pus_pkg::pus_sleep_t pm_sleep_state
);
	// ==========================================
	// supply ramps
	logic [3:0] io_age = 4'h0;
	logic [3:0] core_age = 4'h0;
	// rails read stable only after lag edges of power, so slow ramps are possible
	always @(posedge sys_clk) begin
		io_age <= (!io_on) ? 4'h0 : (io_age == 4'hF) ? io_age : io_age + 4'h1;
		core_age <= (!core_on) ? 4'h0 : (core_age == 4'hF) ? core_age : core_age + 4'h1;
	end
	// a loss is reported at once, a monitor never lags a brown-out
	assign io_supply_ok = io_on && (io_age >= lag);
	assign core_supply_ok = core_on && (core_age >= lag);
	assign pm_sleep_state = sleep_req;
endmodule

// ===== dv/test_power_up_reset_sequencer.sv
// self-checking bench for the power-up reset sequencer
`timescale 1ns/1ns
module test_power_up_reset_sequencer;
	localparam int STB = 2;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic io_on = 1'b0;
	logic core_on = 1'b0;
	logic [3:0] lag = 4'h0;
	pus_pkg::pus_sleep_t sleep_req = pus_pkg::PUS_SLEEP_ACTIVE;
	logic sw_switching_req = 1'b0;
	logic [7:0] sw_gclk_enable = 8'h00;
	logic sw_gclk_write = 1'b0;
	logic io_supply_ok;
	logic core_supply_ok;
	pus_pkg::pus_sleep_t pm_sleep_state;
	logic chip_reset_n;
	logic perf_level;
	logic cpu_fetch_start;
	pus_pkg::pus_reg_mode_t reg_mode;
	pus_pkg::pus_clk_cfg_t clk_cfg;
	logic [31:0] pin_oe_n;
	logic [31:0] pin_pull_up;
	logic [31:0] pin_input_en;
	logic [31:0] cpu_boot_addr;
	int fail_count = 0;
	int total_checks = 0;
	int n;
	logic [7:0] mask;
	logic [1:0] s;
	logic w = 1'b0;

	// ==========================================
	// design and far side
	pus_sequencer #(.STABLE_CYCLES(STB)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.io_supply_ok(io_supply_ok), .core_supply_ok(core_supply_ok), .pm_sleep_state(pm_sleep_state),
		.sw_switching_req(sw_switching_req), .sw_gclk_enable(sw_gclk_enable), .sw_gclk_write(sw_gclk_write),
		.chip_reset_n(chip_reset_n), .perf_level(perf_level), .reg_mode(reg_mode), .clk_cfg(clk_cfg),
		.pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up), .pin_input_en(pin_input_en),
		.cpu_boot_addr(cpu_boot_addr), .cpu_fetch_start(cpu_fetch_start));
	pus_supply_model supplies (.sys_clk(sys_clk), .io_on(io_on), .core_on(core_on), .lag(lag),
		.sleep_req(sleep_req), .io_supply_ok(io_supply_ok), .core_supply_ok(core_supply_ok),
		.pm_sleep_state(pm_sleep_state));

	// 40 ns clock
	initial forever #20 sys_clk = ~sys_clk;

	// ==========================================
	// helpers
	task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask
	// sample at the falling edge so the rising edge updates have landed
	task automatic tick(int k);
		repeat (k) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic gclk_pulse(logic [7:0] m);
		@(posedge sys_clk);
		sw_gclk_enable <= m;
		sw_gclk_write <= 1'b1;
		@(posedge sys_clk);
		sw_gclk_write <= 1'b0;
	endtask
	function automatic pus_pkg::pus_reg_mode_t exp_mode(logic [1:0] st, logic sw);
		if (st == pus_pkg::PUS_SLEEP_STANDBY) return pus_pkg::PUS_REG_LOW_POWER;
		if (st == pus_pkg::PUS_SLEEP_BACKUP) return pus_pkg::PUS_REG_SHUTDOWN;
		return sw ? pus_pkg::PUS_REG_SWITCHING : pus_pkg::PUS_REG_LINEAR;
	endfunction
	function automatic pus_pkg::pus_clk_cfg_t exp_cfg(logic [7:0] m);
		return {1'b1, pus_pkg::PUS_OSC_FREQ_SEL_4MHZ, pus_pkg::PUS_MAIN_GEN_INDEX, m};
	endfunction
	// one cycle of slack each way on the sync plus count latency
	task automatic wait_release(int lo, int hi);
		n = 0;
		while (chip_reset_n !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		check(32'(n >= lo && n <= hi), 32'h1, "release latency");
		check(32'(cpu_fetch_start), 32'h1, "fetch with release");
		check(cpu_boot_addr, pus_pkg::PUS_RESET_ADDRESS, "boot address");
		tick(1);
		check(32'(cpu_fetch_start), 32'h0, "fetch pulse width");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ==========================================
	// tests
	initial begin
		void'($urandom(32'h37A39F45));
		tick(9);
		check(32'(chip_reset_n), 32'h0, "held during reset");
		@(posedge sys_clk);
		reset_n <= 1'b1;
		io_on <= 1'b1;
		tick(20);
		check(32'(chip_reset_n), 32'h0, "io rail alone");
		check(32'(reg_mode), 32'(pus_pkg::PUS_REG_LINEAR), "mode in hold");
		gclk_pulse(8'hA5);
		@(posedge sys_clk);
		core_on <= 1'b1;
		tick(0);
		check(32'(clk_cfg), 32'(exp_cfg(pus_pkg::PUS_DEFAULT_CLK_MASK)), "write refused in hold");
		wait_release(STB + 2, STB + 4);
		// clock, pin and level defaults after release
		check(32'(clk_cfg), 32'(exp_cfg(pus_pkg::PUS_DEFAULT_CLK_MASK)), "clock defaults");
		check(32'(perf_level), 32'(pus_pkg::PUS_LOWEST_PERF_LEVEL), "perf level");
		check(pin_oe_n, 32'hFFFFFFFF, "pins tri-stated");
		check(pin_pull_up, 32'h40000000, "debug pin pull-up");
		check(pin_input_en, 32'h40000000, "debug pin input");
		$display("test hold_release done");
		mask = 8'($urandom);
		gclk_pulse(mask);
		tick(2);
		check(32'(clk_cfg), 32'(exp_cfg(mask)), "clock mask load");
		$display("test gclk_write done");
		// mode follows the sleep state, every state with both requests first
		for (int i = 0; i < 48; i++) begin
			s = (i < 8) ? 2'(i) : 2'($urandom_range(3));
			if (i < 8) w = i[2];
			else if (s == 2'h0) w = 1'($urandom);
			@(posedge sys_clk);
			sleep_req <= pus_pkg::pus_sleep_t'(s);
			sw_switching_req <= w;
			tick(2);
			check(32'(reg_mode), 32'(exp_mode(s, w)), "regulator mode");
		end
		$display("test regulator done");
		// loss of the core rail re-holds, slow ramp on return
		@(posedge sys_clk);
		sleep_req <= pus_pkg::PUS_SLEEP_ACTIVE;
		sw_switching_req <= 1'b0;
		lag <= 4'h3;
		core_on <= 1'b0;
		tick(4);
		check(32'(chip_reset_n), 32'h0, "re-held on loss");
		@(posedge sys_clk);
		core_on <= 1'b1;
		tick(0);
		wait_release(STB + 5, STB + 7);
		check(pin_oe_n, 32'hFFFFFFFF, "pins after re-release");
		$display("test supply_loss done");
		// mid-run reset clears software settings, supplies stay stable
		gclk_pulse(8'hF0);
		sw_switching_req <= 1'b1;
		@(posedge sys_clk);
		reset_n <= 1'b0;
		tick(2);
		check(32'(chip_reset_n), 32'h0, "held in mid-run reset");
		check(32'(clk_cfg), 32'(exp_cfg(pus_pkg::PUS_DEFAULT_CLK_MASK)), "clocks in mid-run reset");
		check(32'(reg_mode), 32'(pus_pkg::PUS_REG_LINEAR), "mode in mid-run reset");
		@(posedge sys_clk);
		reset_n <= 1'b1;
		sw_switching_req <= 1'b0;
		tick(0);
		wait_release(STB + 2, STB + 4);
		$display("test mid_reset done");
		summarize();
	end

	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (3000) @(posedge sys_clk);
		fail_count++;
		$display("BAD t=%0t watchdog expired", $time);
		summarize();
	end
endmodule
